// file: bench/tb_dpeiu_top.sv
// tb_dpeiu_top: self-checking bench for the loop event interrupt unit.
// assumes the host port answers reads one edge after the strobe edge.
`timescale 1ns/1ps
module tb_dpeiu_top;
    import dpeiu_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] host_addr = 16'h0000;
    logic [15:0] host_wdata = 16'h0000;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [15:0] host_rdata;
    logic irq_out;
    logic lock_status = 1'b0;
    logic [1:0] selected_ref = 2'h0;
    logic [1:0] timing_mode = 2'h1;
    logic [15:0] period_fail_raw = 16'h0000;
    logic [15:0] period_check_mask = 16'h0000;
    int err_count = 0;
    int compares = 0;
    dpeiu_top dpeiu_top_i (.mclk(mclk), .reset(reset), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rdata(host_rdata), .irq_out(irq_out), .lock_status(lock_status),
        .selected_ref(selected_ref), .timing_mode(timing_mode),
        .period_fail_raw(period_fail_raw), .period_check_mask(period_check_mask));
    // 8 ns clock
    initial begin
        forever #4 mclk = ~mclk;
    end
    task wrap_up;
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t irq %b expected %b", $time, got, exp);
        end
    endtask : chk1
    // one-cycle write strobe, released on the same edge that takes it
    task wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge mclk);
        host_wr <= 1'b0;
    endtask : wr_reg
    // data is taken one edge late on purpose; it holds until the next read
    task rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge mclk);
        host_rd <= 1'b0;
        @(posedge mclk);
        #1;
        chk16(host_rdata, exp);
    endtask : rd_chk
    task settle_irq(input logic exp);
        repeat (3) @(posedge mclk);
        #1;
        chk1(irq_out, exp);
    endtask : settle_irq
    task t_reset;
        rd_chk(DPEIU_OFS_MASK, 16'h0001);
        rd_chk(DPEIU_OFS_FLAGS, 16'h0000);
        rd_chk(DPEIU_OFS_FAIL, 16'h0000);
        rd_chk(16'h0070, 16'h0000);
        rd_chk(DPEIU_OFS_CLEAR, 16'h0000);
        chk1(irq_out, 1'b0);
        wr_reg(DPEIU_OFS_MASK, 16'h000F);
        rd_chk(DPEIU_OFS_MASK, 16'h000F);
        $display("test reset and mask done");
    endtask : t_reset
    // lock, reference and holdover events in turn, masked first
    task t_events;
        logic [15:0] b;
        for (int i = 0; i < 3; i++) begin
            b = 16'h0008 >> i;
            wr_reg(DPEIU_OFS_MASK, 16'h0001 | b);
            @(posedge mclk);
            if (i == 0) lock_status <= ~lock_status;
            if (i == 1) selected_ref <= selected_ref + 2'h1;
            if (i == 2) timing_mode <= DPEIU_MODE_HOLDOVER;
            settle_irq(1'b0);
            rd_chk(DPEIU_OFS_FLAGS, b);
            wr_reg(DPEIU_OFS_FLAGS, 16'hFFFF);
            rd_chk(DPEIU_OFS_FLAGS, b);
            wr_reg(DPEIU_OFS_MASK, 16'h0001);
            settle_irq(1'b1);
            wr_reg(DPEIU_OFS_CLEAR, 16'h0001 | b);
            rd_chk(DPEIU_OFS_FLAGS, 16'h0000);
            chk1(irq_out, 1'b0);
        end
        $display("test events done");
    endtask : t_events
    task t_race;
        @(posedge mclk);
        lock_status <= ~lock_status;
        host_addr <= DPEIU_OFS_CLEAR;
        host_wdata <= 16'h0009;
        host_wr <= 1'b1;
        @(posedge mclk);
        host_wr <= 1'b0;
        rd_chk(DPEIU_OFS_FLAGS, 16'h0008);
        wr_reg(DPEIU_OFS_CLEAR, 16'h0009);
        @(posedge mclk);
        timing_mode <= DPEIU_MODE_PHASE_HOLD;
        rd_chk(DPEIU_OFS_FLAGS, 16'h0000);
        @(posedge mclk);
        timing_mode <= 2'h1;
        rd_chk(DPEIU_OFS_FLAGS, 16'h0002);
        settle_irq(1'b1);
        wr_reg(DPEIU_OFS_CLEAR, 16'h0003);
        rd_chk(DPEIU_OFS_FLAGS, 16'h0000);
        // holdover entry lands in the same cycle as its clear strobe
        @(posedge mclk);
        timing_mode <= DPEIU_MODE_HOLDOVER;
        host_addr <= DPEIU_OFS_CLEAR;
        host_wdata <= 16'h0003;
        host_wr <= 1'b1;
        @(posedge mclk);
        host_wr <= 1'b0;
        rd_chk(DPEIU_OFS_FLAGS, 16'h0002);
        wr_reg(DPEIU_OFS_CLEAR, 16'h0003);
        rd_chk(DPEIU_OFS_FLAGS, 16'h0000);
        $display("test set against clear done");
    endtask : t_race
    task t_fail;
        @(posedge mclk);
        period_fail_raw <= 16'hA5C3;
        period_check_mask <= 16'h0F0F;
        rd_chk(DPEIU_OFS_FAIL, 16'hA0C0);
        wr_reg(DPEIU_OFS_FAIL, 16'hFFFF);
        rd_chk(DPEIU_OFS_FAIL, 16'hA0C0);
        @(posedge mclk);
        period_fail_raw <= 16'h5A3C;
        rd_chk(DPEIU_OFS_FAIL, 16'h5030);
        $display("test failure status done");
    endtask : t_fail
    // hang guard: a run this long means something stalled
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_events();
        t_race();
        t_fail();
        wrap_up();
    end
endmodule : tb_dpeiu_top

// file: src/dpeiu_event_flag.sv
// dpeiu_event_flag: sticky flag raised when a watched level changes.
// assumes the watched level comes from logic on mclk, so no synchroniser.
`timescale 1ns/1ps
module dpeiu_event_flag
    import dpeiu_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic arm,
    input wire logic [W-1:0] level_in,
    input wire logic clear,
    output logic flag,
    output logic changed
);
    logic [W-1:0] prev_reg;
    logic flag_reg;
    logic flag_next;

    // no event until prev holds a real sample, avoids a false one at reset
    assign changed = arm && (level_in != prev_reg);
    // set beats clear in the same cycle
    assign flag_next = changed || (flag_reg && !clear);
    assign flag = flag_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
            flag_reg <= flag_next;
        end
    end
endmodule : dpeiu_event_flag

// file: src/dpeiu_pkg.sv
// dpeiu_pkg: offsets, field positions and reset values for the loop event
// interrupt unit; shared by the unit top and its event flag cell.
package dpeiu_pkg;
    localparam int DPEIU_ADDR_W = 16;
    localparam int DPEIU_DATA_W = 16;
    // register offsets on the host port
    localparam logic [15:0] DPEIU_OFS_FLAGS = 16'h0066;
    localparam logic [15:0] DPEIU_OFS_MASK = 16'h0067;
    localparam logic [15:0] DPEIU_OFS_CLEAR = 16'h0068;
    localparam logic [15:0] DPEIU_OFS_FAIL = 16'h0069;
    // event bit positions in flags, mask and clear words
    localparam int DPEIU_BIT_LOCK = 3;
    localparam int DPEIU_BIT_REF = 2;
    localparam int DPEIU_BIT_HOLD = 1;
    // values after reset
    localparam logic [15:0] DPEIU_MASK_RST = 16'h0001;
    localparam logic [15:0] DPEIU_WORD_RST = 16'h0000;
    // timing mode codes seen from the loop
    localparam logic [1:0] DPEIU_MODE_PHASE_HOLD = 2'h0;
    localparam logic [1:0] DPEIU_MODE_HOLDOVER = 2'h2;
endpackage : dpeiu_pkg

// file: src/dpeiu_top.sv
// dpeiu_top: event flags, interrupt mask, clear strobes and reference
// failure status of the clock recovery loop, on the parallel host port.
// assumes loop status and period check results are synchronous to mclk.
//
// Function
// - the interrupt output is active while any flag is set and its mask bit is low.
// - writing a one to a clear bit drops the flag in that position.
// - the lock change flag sits at bit 3 of the flag word.
// - the flag word is read only, holds the holdover flag at bit 1, and writes leave it alone.
// - unused bits of the flag word read as zero.
// - the mask word is read/write, bits 3, 2 and 1 mask lock, reference and holdover events.
// - clear word bits 3 to 1 strobe clears of the flags in the same positions.
// - the failure status word at 0069 is read only, one nibble per reference, reference 3 on top.
// - any change of the lock status sets the lock change flag.
// - any change of the selected reference sets the reference change flag at bit 2.
// - entering or leaving holdover or phase hold sets the holdover flag; a move between those two modes does not.
`timescale 1ns/1ps
module dpeiu_top
    import dpeiu_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [DPEIU_ADDR_W-1:0] host_addr,
    input wire logic [DPEIU_DATA_W-1:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_rd,
    output logic [DPEIU_DATA_W-1:0] host_rdata,
    output logic irq_out,
    input wire logic lock_status,
    input wire logic [1:0] selected_ref,
    input wire logic [1:0] timing_mode,
    input wire logic [15:0] period_fail_raw,
    input wire logic [15:0] period_check_mask
);
    logic arm_reg;
    logic [15:0] mask_reg;
    logic [15:0] fail_reg;
    logic [15:0] rdata_reg;
    logic irq_reg;
    logic lock_change_flag;
    logic reference_change_flag;
    logic holdover_event_flag;
    logic lock_changed;
    logic ref_changed;
    logic hold_changed;
    logic in_hold;

    // address decode
    wire hit_flags = (host_addr == DPEIU_OFS_FLAGS);
    wire hit_mask = (host_addr == DPEIU_OFS_MASK);
    wire hit_clear = (host_addr == DPEIU_OFS_CLEAR);
    wire hit_fail = (host_addr == DPEIU_OFS_FAIL);
    wire [15:0] flag_clear_strobes = (host_wr && hit_clear) ? host_wdata : 16'h0000;
    wire [15:0] flags_word = {12'h000, lock_change_flag, reference_change_flag,
        holdover_event_flag, 1'b0};
    wire [3:1] pending = flags_word[3:1] & ~mask_reg[3:1];
    wire [15:0] fail_next = period_fail_raw & ~period_check_mask;
    // unmapped and write-only offsets read as zero
    wire [15:0] rd_mux = hit_flags ? flags_word :
        hit_mask ? mask_reg :
        hit_fail ? fail_reg : 16'h0000;

    // phase hold counts as holdover for the event
    assign in_hold = (timing_mode == DPEIU_MODE_HOLDOVER) ||
        (timing_mode == DPEIU_MODE_PHASE_HOLD);

    // one cell per event; sticky until its clear strobe
    dpeiu_event_flag #(.W(1)) u_lock (
        .mclk(mclk),
        .reset(reset),
        .arm(arm_reg),
        .level_in(lock_status),
        .clear(flag_clear_strobes[DPEIU_BIT_LOCK]),
        .flag(lock_change_flag),
        .changed(lock_changed)
    );
    dpeiu_event_flag #(.W(2)) u_ref (
        .mclk(mclk),
        .reset(reset),
        .arm(arm_reg),
        .level_in(selected_ref),
        .clear(flag_clear_strobes[DPEIU_BIT_REF]),
        .flag(reference_change_flag),
        .changed(ref_changed)
    );
    dpeiu_event_flag #(.W(1)) u_hold (
        .mclk(mclk),
        .reset(reset),
        .arm(arm_reg),
        .level_in(in_hold),
        .clear(flag_clear_strobes[DPEIU_BIT_HOLD]),
        .flag(holdover_event_flag),
        .changed(hold_changed)
    );

    // register file; writes to flag and status words are ignored
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            arm_reg <= 1'b0;
            mask_reg <= DPEIU_MASK_RST;
            fail_reg <= DPEIU_WORD_RST;
            rdata_reg <= DPEIU_WORD_RST;
            irq_reg <= 1'b0;
        end else begin
            arm_reg <= 1'b1;
            if (host_wr && hit_mask) begin
                mask_reg <= host_wdata;
            end
            fail_reg <= fail_next;
            irq_reg <= |pending;
            if (host_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign host_rdata = rdata_reg;
    assign irq_out = irq_reg;

    // checks
    sequence s_clear_write(int b);
        host_wr && hit_clear && host_wdata[b];
    endsequence

    property p_irq_follows;
        @(posedge mclk) disable iff (reset)
        (|pending) |=> irq_out;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

    property p_irq_quiet;
        @(posedge mclk) disable iff (reset)
        ((flags_word[3:1] & ~mask_reg[3:1]) == 3'h0) |=> !irq_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised while masked");

    property p_clear_lock;
        @(posedge mclk) disable iff (reset)
        (s_clear_write(DPEIU_BIT_LOCK) and !lock_changed) |=> !lock_change_flag;
    endproperty
    a_clear_lock: assert property (p_clear_lock) else $error("lock flag not cleared");

    property p_lock_set;
        @(posedge mclk) disable iff (reset)
        lock_changed |=> (lock_change_flag && flags_word[3]);
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock flag not set");

    property p_ref_set;
        @(posedge mclk) disable iff (reset)
        (arm_reg && selected_ref != $past(selected_ref)) |=> flags_word[2];
    endproperty
    a_ref_set: assert property (p_ref_set) else $error("ref flag not set");

    property p_hold_win;
        @(posedge mclk) disable iff (reset)
        (s_clear_write(DPEIU_BIT_HOLD) and hold_changed) |=> flags_word[1];
    endproperty
    a_hold_win: assert property (p_hold_win) else $error("event lost to clear");

    property p_flag_write;
        @(posedge mclk) disable iff (reset)
        (host_wr && hit_flags && !lock_changed && !ref_changed && !hold_changed
            && !hit_clear) |=> $stable(flags_word);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag word written");

    property p_sticky;
        @(posedge mclk) disable iff (reset)
        (lock_change_flag && !flag_clear_strobes[DPEIU_BIT_LOCK]) |=> lock_change_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

    property p_read_flags;
        @(posedge mclk) disable iff (reset)
        (host_rd && hit_flags) |=> (host_rdata[15:4] == 12'h000 && !host_rdata[0]);
    endproperty
    a_read_flags: assert property (p_read_flags) else $error("unused flag bits");

    property p_read_fail;
        @(posedge mclk) disable iff (reset)
        (host_rd && hit_fail) |=> (host_rdata == $past(fail_reg));
    endproperty
    a_read_fail: assert property (p_read_fail) else $error("fail status read");

    property p_fail_track;
        @(posedge mclk) disable iff (reset)
        1'b1 |=> (fail_reg == $past(period_fail_raw & ~period_check_mask));
    endproperty
    a_fail_track: assert property (p_fail_track) else $error("fail status stale");

    property p_mask_rw;
        @(posedge mclk) disable iff (reset)
        (host_wr && hit_mask) |=> (mask_reg == $past(host_wdata));
    endproperty
    a_mask_rw: assert property (p_mask_rw) else $error("mask not written");
endmodule : dpeiu_top
